// File: design/smrt_map.vh
`ifndef SMRT_MAP_VH
`define SMRT_MAP_VH

// Core clock rate and derived cycles per time unit
`define SMRT_CLK_HZ            32'h0098_9680
`define SMRT_CYC_PER_MS        (`SMRT_CLK_HZ / 32'h0000_03E8)
`define SMRT_CYC_PER_US        (`SMRT_CLK_HZ / 32'h000F_4240)

// Internal fixed timeout, 200 ms
`define SMRT_INT_TIMEOUT_MS    32'h0000_00C8
`define SMRT_INT_TIMEOUT_CYC   (`SMRT_INT_TIMEOUT_MS * `SMRT_CYC_PER_MS)

// Floating pin timeout, 400 us, also the floor of capacitor mode
`define SMRT_FLOAT_TIMEOUT_US  32'h0000_0190
`define SMRT_FLOAT_TIMEOUT_CYC (`SMRT_FLOAT_TIMEOUT_US * `SMRT_CYC_PER_US)

// Capacitor scaling, 110 pF for each millisecond of timeout
`define SMRT_PF_PER_MS         16'h006E

// Timeout modes, one-hot
`define SMRT_MODE_INT          3'h1
`define SMRT_MODE_CAP          3'h2
`define SMRT_MODE_CMP          3'h4

// Reset generator states, one-hot
`define SMRT_ST_FAULT          3'h1
`define SMRT_ST_TIMING         3'h2
`define SMRT_ST_RELEASED       3'h4

// Reset values
`define SMRT_RST_VALID         1'h0
`define SMRT_RST_COUNT         32'h0000_0000

`endif

// File: design/smrt_channel.v
`timescale 1ns/100ps
`include "smrt_map.vh"

// One adjustable monitor input: synchronises the comparator taps and
// applies polarity and the one-sided hysteresis of comparator mode.
module smrt_channel (
   input  wire core_clk,
   input  wire reset_n,
   input  wire hyst_en,
   input  wire positive_pol_pin,
   input  wire above_nom_pin,
   input  wire above_hi_pin,
   input  wire above_lo_pin,
   output reg  valid_reg
);

   reg  [3:0] sync1_reg;
   reg  [3:0] sync2_reg;
   reg        thr_ok;
   wire       pos_pol;
   wire       above_nom;
   wire       above_hi;
   wire       above_lo;

   assign pos_pol   = sync2_reg[3];
   assign above_nom = sync2_reg[2];
   assign above_hi  = sync2_reg[1];
   assign above_lo  = sync2_reg[0];

   // Two-stage synchroniser; analog comparators are asynchronous to core_clk
   // Reset pattern reads as a positive input below 500 mV, so no channel looks
   // valid before real samples arrive; an all-zero pattern would fake a valid input
   always @(posedge core_clk) begin
      if (!reset_n) begin
         sync1_reg <= 4'h8;
         sync2_reg <= 4'h8;
      end else begin
         sync1_reg <= {positive_pol_pin, above_nom_pin, above_hi_pin, above_lo_pin};
         sync2_reg <= sync1_reg;
      end
   end

   // Threshold choice; the shifted tap is used only while invalid in comparator mode
   always @* begin
      if (pos_pol) begin
         if (hyst_en && !valid_reg)
            thr_ok = above_hi;   // Recover above 503.5 mV [R08] [R09]
         else
            thr_ok = above_nom;  // Valid above 500 mV [R18] [R20]
      end else begin
         if (hyst_en && !valid_reg)
            thr_ok = !above_lo;  // Recover below 496.5 mV [R08] [R10]
         else
            thr_ok = !above_nom; // Valid below 500 mV [R18] [R20]
      end
   end

   // Channel validity state
   always @(posedge core_clk) begin
      if (!reset_n)
         valid_reg <= `SMRT_RST_VALID;
      else
         valid_reg <= thr_ok;
   end

endmodule // smrt_channel

// File: design/smrt_reset_timer.v
`timescale 1ns/100ps
`include "smrt_map.vh"

// Function
// R01 - Release reset after timeout, all inputs valid
// R02 - Three timeout modes chosen by timing pin
// R03 - Pin grounded gives internal 200 ms timeout
// R04 - Capacitor sets timeout, up to nine seconds
// R05 - Timeout scales at 110 pF per ms
// R06 - Floating pin gives about 400 us timeout
// R07 - Pin at supply bypasses timer entirely
// R08 - Comparator mode adds one-sided hysteresis only
// R09 - Positive input recovers above 503.5 mV
// R10 - Negative input recovers below 496.5 mV
// R11 - Discharged capacitor starts internal timer first
// R12 - Integrator limits capacitor to about 1 uF
// R13 - Supply lockout monitor at 11.5 percent below
// R14 - No timeout until supply lockout is valid
// R15 - Comparator mode needs pin shorted to supply
// R16 - Invalid input pulls channel and reset low
// R17 - Fault aborts count; restart from zero
// R18 - Polarity decides above or below 0.5 V
// R19 - Decode mode before each timeout, hold it
// R20 - No hysteresis in timer modes
module smrt_reset_timer #(
   parameter CAP_W           = 20,
   parameter INT_TIMEOUT_CYC = `SMRT_INT_TIMEOUT_CYC
) (
   input  wire             core_clk,
   input  wire             reset_n,
   input  wire             supply_lockout_monitor,
   input  wire             timing_pin_at_ground,
   input  wire             timing_pin_at_supply,
   input  wire [CAP_W-1:0] timing_capacitor_pf,
   input  wire             monitor_input_a_pos_pol,
   input  wire             monitor_input_a_above_nom,
   input  wire             monitor_input_a_above_hi,
   input  wire             monitor_input_a_above_lo,
   input  wire             monitor_input_b_pos_pol,
   input  wire             monitor_input_b_above_nom,
   input  wire             monitor_input_b_above_hi,
   input  wire             monitor_input_b_above_lo,
   input  wire             system_reset_in,
   output reg              system_reset_out,
   output reg              system_reset_oe_n,
   input  wire             channel_a_good_in,
   output reg              channel_a_good_out,
   output reg              channel_a_good_oe_n,
   input  wire             channel_b_good_in,
   output reg              channel_b_good_out,
   output reg              channel_b_good_oe_n,
   output reg  [2:0]       timeout_mode,
   output reg              timer_running
);

   localparam [31:0] INT_CYC   = INT_TIMEOUT_CYC;
   localparam [31:0] FLOAT_CYC = `SMRT_FLOAT_TIMEOUT_CYC;
   localparam [47:0] PF_MS     = {32'h0, `SMRT_PF_PER_MS};
   localparam [47:0] CYC_MS    = {16'h0, `SMRT_CYC_PER_MS};

   // Timing pin decode, shared by mode load and the start-up upgrade
   function [2:0] smrt_decode;
      input at_gnd;
      input at_sup;
      begin
         if (at_sup)
            smrt_decode = `SMRT_MODE_CMP;
         else if (at_gnd)
            smrt_decode = `SMRT_MODE_INT;
         else
            smrt_decode = `SMRT_MODE_CAP;
      end
   endfunction

   reg  [2:0]       pin_s1_reg;
   reg  [2:0]       pin_s2_reg;
   reg  [CAP_W-1:0] cap_s1_reg;
   reg  [CAP_W-1:0] cap_s2_reg;
   reg  [2:0]       state_reg;
   reg  [2:0]       state_next;
   reg  [2:0]       mode_reg;
   reg  [2:0]       mode_next;
   reg  [31:0]      count_reg;
   reg  [31:0]      count_next;
   reg              done;
   wire             valid_a;
   wire             valid_b;
   wire             supply_ok;
   wire             all_valid;
   wire             hyst_en;
   wire [2:0]       pin_mode;
   wire [31:0]      count_inc;
   wire [47:0]      elapsed_pf;
   wire [47:0]      cap_target;

   // Synchronise lockout and timing pin senses, and the capacitance value
   always @(posedge core_clk) begin
      if (!reset_n) begin
         pin_s1_reg <= 3'h2;                                            // Lockout bad, pin at ground
         pin_s2_reg <= 3'h2;                                            // [R11]
         cap_s1_reg <= {CAP_W{1'b0}};
         cap_s2_reg <= {CAP_W{1'b0}};
      end else begin
         pin_s1_reg <= {supply_lockout_monitor, timing_pin_at_ground, timing_pin_at_supply};
         pin_s2_reg <= pin_s1_reg;
         cap_s1_reg <= timing_capacitor_pf;
         cap_s2_reg <= cap_s1_reg;
      end
   end

   assign supply_ok = pin_s2_reg[2];
   assign pin_mode  = smrt_decode(pin_s2_reg[1], pin_s2_reg[0]);       // [R02]
   assign hyst_en   = (mode_reg == `SMRT_MODE_CMP);                     // [R08] [R20]

   // Adjustable monitor channels
   smrt_channel u_chan_a (
      .core_clk         (core_clk),
      .reset_n          (reset_n),
      .hyst_en          (hyst_en),
      .positive_pol_pin (monitor_input_a_pos_pol),
      .above_nom_pin    (monitor_input_a_above_nom),
      .above_hi_pin     (monitor_input_a_above_hi),
      .above_lo_pin     (monitor_input_a_above_lo),
      .valid_reg        (valid_a)
   );

   smrt_channel u_chan_b (
      .core_clk         (core_clk),
      .reset_n          (reset_n),
      .hyst_en          (hyst_en),
      .positive_pol_pin (monitor_input_b_pos_pol),
      .above_nom_pin    (monitor_input_b_above_nom),
      .above_hi_pin     (monitor_input_b_above_hi),
      .above_lo_pin     (monitor_input_b_above_lo),
      .valid_reg        (valid_b)
   );

   // Supply lockout result gates the timer and reset, not the channel good outputs; its threshold is analog [R13]
   assign all_valid = supply_ok & valid_a & valid_b;                   // [R01] [R14]

   // Capacitor timeout compare: elapsed_cycles * 110 >= pF * cycles_per_ms
   assign count_inc  = count_reg + 32'h0000_0001;
   assign elapsed_pf = {16'h0, count_inc} * PF_MS;                     // [R05]
   assign cap_target = {{(48-CAP_W){1'b0}}, cap_s2_reg} * CYC_MS;       // [R04]

   // Timeout reached in the held mode
   always @* begin
      case (mode_reg)
         `SMRT_MODE_INT: done = (count_inc >= INT_CYC);                 // [R03]
         // Floor of 400 us covers the open pin [R06]
         `SMRT_MODE_CAP: done = (count_inc >= FLOAT_CYC) && (elapsed_pf >= cap_target);
         default:        done = 1'b1;
      endcase
   end

   // Reset generator; mode is loaded only in the fault state, except the internal-to-capacitor upgrade
   always @* begin
      state_next = state_reg;
      mode_next  = mode_reg;
      count_next = `SMRT_RST_COUNT;
      case (state_reg)
         `SMRT_ST_FAULT: begin
            mode_next = pin_mode;                                       // [R19]
            if (all_valid) begin
               if (pin_mode == `SMRT_MODE_CMP)
                  state_next = `SMRT_ST_RELEASED;                       // [R07]
               else
                  state_next = `SMRT_ST_TIMING;                         // [R01]
            end
         end
         `SMRT_ST_TIMING: begin
            // A discharged capacitor looks grounded; once it leaves ground the
            // count continues as capacitor mode, else 200 ms ends it early
            if (mode_reg == `SMRT_MODE_INT && pin_mode == `SMRT_MODE_CAP)
               mode_next = `SMRT_MODE_CAP;                              // [R11]
            if (!all_valid)
               state_next = `SMRT_ST_FAULT;                             // [R17]
            else if (done)
               state_next = `SMRT_ST_RELEASED;                          // [R01]
            else
               count_next = count_inc;
         end
         `SMRT_ST_RELEASED: begin
            if (!all_valid)
               state_next = `SMRT_ST_FAULT;                             // [R16]
         end
         default: begin
            state_next = `SMRT_ST_FAULT;
         end
      endcase
   end

   always @(posedge core_clk) begin
      if (!reset_n) begin
         state_reg <= `SMRT_ST_FAULT;
         mode_reg  <= `SMRT_MODE_INT;
         count_reg <= `SMRT_RST_COUNT;
      end else begin
         state_reg <= state_next;
         mode_reg  <= mode_next;
         count_reg <= count_next;                                       // [R17]
      end
   end

   // Open-drain pins: output is always low, enable active low pulls the line
   // The pin inputs are not used; another driver may hold the wired-OR reset low
   always @(posedge core_clk) begin
      if (!reset_n) begin
         system_reset_out    <= 1'b0;
         system_reset_oe_n   <= 1'b0;
         channel_a_good_out  <= 1'b0;
         channel_a_good_oe_n <= 1'b0;
         channel_b_good_out  <= 1'b0;
         channel_b_good_oe_n <= 1'b0;
         timeout_mode        <= `SMRT_MODE_INT;
         timer_running       <= 1'b0;
      end else begin
         system_reset_out    <= 1'b0;
         system_reset_oe_n   <= (state_next == `SMRT_ST_RELEASED);      // [R01] [R16]
         channel_a_good_out  <= 1'b0;
         channel_a_good_oe_n <= valid_a;                                // [R16]
         channel_b_good_out  <= 1'b0;
         channel_b_good_oe_n <= valid_b;                                // [R16]
         timeout_mode        <= mode_next;
         timer_running       <= (state_next == `SMRT_ST_TIMING);
      end
   end

endmodule // smrt_reset_timer

// File: verif/smrt_reset_timer_sva.sv
`timescale 1ns/100ps
// Port-level checks of the reset timer
module smrt_reset_timer_sva #(
   parameter INT_TIMEOUT_CYC = 50
) (
   input wire       core_clk,
   input wire       reset_n,
   input wire       supply_lockout_monitor,
   input wire       monitor_input_a_pos_pol,
   input wire       monitor_input_a_above_nom,
   input wire       monitor_input_b_pos_pol,
   input wire       monitor_input_b_above_nom,
   input wire       system_reset_oe_n,
   input wire       channel_a_good_oe_n,
   input wire       channel_b_good_oe_n,
   input wire [2:0] timeout_mode,
   input wire       timer_running
);
   reg [31:0] run_cnt_reg;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // Length of the current count; cleared on abort so a restart is judged from zero
   always @(posedge core_clk) begin
      if (!reset_n || !timer_running) run_cnt_reg <= 32'h0000_0000;
      else run_cnt_reg <= run_cnt_reg + 32'h0000_0001;
   end
   a_lock_holds_rst: assert property (!supply_lockout_monitor [*5] |->
      !system_reset_oe_n && !timer_running) else $error("released under supply lockout");
   a_chan_a_fault: assert property ((monitor_input_a_pos_pol &&
      !monitor_input_a_above_nom) [*6] |-> !channel_a_good_oe_n) else $error("a not low");
   a_chan_b_fault: assert property ((!monitor_input_b_pos_pol &&
      monitor_input_b_above_nom) [*6] |-> !channel_b_good_oe_n) else $error("b not low");
   a_fault_pulls_rst: assert property ($fell(channel_a_good_oe_n) |->
      ##[0:4] !system_reset_oe_n) else $error("reset not pulled on fault");
   a_release_valid: assert property ($rose(system_reset_oe_n) |->
      channel_a_good_oe_n && channel_b_good_oe_n) else $error("release with bad channel");
   a_int_count: assert property ($rose(system_reset_oe_n) && timeout_mode == 3'h1 |->
      run_cnt_reg == INT_TIMEOUT_CYC) else $error("internal timeout length wrong");
   a_cmp_no_timer: assert property (timeout_mode == 3'h4 |-> !timer_running)
      else $error("timer runs in comparator mode");
   a_mode_onehot: assert property ($onehot(timeout_mode))
      else $error("mode not one-hot");
   a_mode_held: assert property (timer_running && $past(timer_running) |->
      $stable(timeout_mode) || ($past(timeout_mode) == 3'h1 && timeout_mode == 3'h2))
      else $error("mode changed mid-count");
   c_int: cover property ($rose(system_reset_oe_n) && timeout_mode == 3'h1);
   c_cap: cover property ($rose(system_reset_oe_n) && timeout_mode == 3'h2);
   c_cmp: cover property ($rose(system_reset_oe_n) && timeout_mode == 3'h4);
   c_abort: cover property ($fell(timer_running) && !system_reset_oe_n);
endmodule // smrt_reset_timer_sva

bind smrt_reset_timer smrt_reset_timer_sva #(.INT_TIMEOUT_CYC(INT_TIMEOUT_CYC)) u_sva (
   .core_clk, .reset_n, .supply_lockout_monitor, .monitor_input_a_pos_pol,
   .monitor_input_a_above_nom, .monitor_input_b_pos_pol, .monitor_input_b_above_nom,
   .system_reset_oe_n, .channel_a_good_oe_n, .channel_b_good_oe_n, .timeout_mode,
   .timer_running);

// File: verif/smrt_sys_model.sv
`timescale 1ns/100ps
// System side of the open-drain lines, each with a pull-up
module smrt_sys_model (
   input  wire rst_out,
   input  wire rst_oe_n,
   input  wire a_out,
   input  wire a_oe_n,
   input  wire b_out,
   input  wire b_oe_n,
   output wire rst_pin,
   output wire a_pin,
   output wire b_pin
);
   // A released line shows the pull-up level, never the last driven value
   assign rst_pin = rst_oe_n ? 1'b1 : rst_out;
   assign a_pin   = a_oe_n ? 1'b1 : a_out;
   assign b_pin   = b_oe_n ? 1'b1 : b_out;
endmodule // smrt_sys_model

// File: verif/smrt_reset_timer_tb.sv
`timescale 1ns/100ps
// Timeout modes, comparator hysteresis, abort and reset of the reset timer
module smrt_reset_timer_tb;
   localparam INT_CYC = 50;
   typedef struct packed {logic g; logic s; logic [19:0] c; int n; logic [2:0] m;} smrt_row_t;
   logic        core_clk, reset_n, lock, gnd, sup;
   logic [19:0] cap;
   logic [1:0]  pol, nom, hi, lo;
   wire         rst_out, rst_oe_n, a_out, a_oe_n, b_out, b_oe_n, run, rst_pin, a_pin, b_pin;
   wire [2:0]   mode;
   int          num_errors, checks_done, cycles, k;
   // 88 pF stays far below the 1 uF ceiling of the capacitor option
   smrt_row_t   rows [3] = '{'{1'b1, 1'b0, 20'h0_0000, INT_CYC, 3'h1},
      '{1'b0, 1'b0, 20'h0_0000, 4000, 3'h2}, '{1'b0, 1'b0, 20'h0_0058, 8000, 3'h2}};
   // Channel, level in tenths of mV, expected line level
   int          hy [6][3] = '{'{0, 4990, 0}, '{0, 5020, 0}, '{0, 5040, 1},
      '{1, 5010, 0}, '{1, 4980, 0}, '{1, 4960, 1}};

   smrt_reset_timer #(.CAP_W(20), .INT_TIMEOUT_CYC(INT_CYC)) DUT (
      .core_clk(core_clk), .reset_n(reset_n), .supply_lockout_monitor(lock),
      .timing_pin_at_ground(gnd), .timing_pin_at_supply(sup), .timing_capacitor_pf(cap),
      .monitor_input_a_pos_pol(pol[0]), .monitor_input_a_above_nom(nom[0]),
      .monitor_input_a_above_hi(hi[0]), .monitor_input_a_above_lo(lo[0]),
      .monitor_input_b_pos_pol(pol[1]), .monitor_input_b_above_nom(nom[1]),
      .monitor_input_b_above_hi(hi[1]), .monitor_input_b_above_lo(lo[1]),
      .system_reset_in(rst_pin), .system_reset_out(rst_out), .system_reset_oe_n(rst_oe_n),
      .channel_a_good_in(a_pin), .channel_a_good_out(a_out), .channel_a_good_oe_n(a_oe_n),
      .channel_b_good_in(b_pin), .channel_b_good_out(b_out), .channel_b_good_oe_n(b_oe_n),
      .timeout_mode(mode), .timer_running(run));
   smrt_sys_model PART (.rst_out(rst_out), .rst_oe_n(rst_oe_n), .a_out(a_out),
      .a_oe_n(a_oe_n), .b_out(b_out), .b_oe_n(b_oe_n), .rst_pin(rst_pin),
      .a_pin(a_pin), .b_pin(b_pin));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // Cuts a hang short; the full run needs about 20300 cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 30000) begin
         num_errors++;
         $display("mismatch at %0t: run timed out", $time);
         end_sim();
      end
   end

   task cyc(input int n);
      repeat (n) @(posedge core_clk);
      #10;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   // Comparator taps for a level in tenths of mV
   task setv(input int ch, input int t);
      nom[ch] = t > 5000;
      hi[ch] = t > 5035;
      lo[ch] = t > 4965;
   endtask
   // Cycles from the start of the count to the release
   task meas(input int n, input string msg);
      k = 0;
      while (run !== 1'b1 && k < 20) begin
         cyc(1);
         k++;
      end
      k = 0;
      while (rst_oe_n !== 1'b1 && k < n + 20) begin
         cyc(1);
         k++;
      end
      chk(k, n, msg);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      reset_n = 1'b0;
      lock = 1'b1;
      gnd = 1'b1;
      sup = 1'b0;
      cap = 20'h0_0000;
      pol = 2'b01;
      setv(0, 5100);
      setv(1, 4900);
      cyc(20);
      chk({rst_oe_n, a_oe_n, b_oe_n, run, mode}, 7'h01, "reset state");
      reset_n = 1'b1;
      foreach (rows[i]) begin
         lock = 1'b0;
         gnd = rows[i].g;
         sup = rows[i].s;
         cap = rows[i].c;
         cyc(8);
         chk(run, 1'b0, "timer under lockout");
         lock = 1'b1;
         meas(rows[i].n, "timeout length");
         chk(mode, rows[i].m, "held mode");
         $display("mode row %0d done", i);
      end
      // Discharged capacitor: count starts as internal, then finishes as capacitor
      lock = 1'b0;
      gnd = 1'b1;
      cyc(8);
      lock = 1'b1;
      cyc(20);
      chk({run, mode}, 4'h9, "start-up internal mode");
      gnd = 1'b0;
      meas(7983, "start-up capacitor timeout");
      chk(mode, 3'h2, "upgraded mode");
      $display("start-up test done");
      lock = 1'b0;
      gnd = 1'b0;
      sup = 1'b1;
      cyc(8);
      lock = 1'b1;
      cyc(6);
      chk({rst_pin, run, mode}, 5'h14, "comparator release");
      foreach (hy[i]) begin
         setv(hy[i][0], hy[i][1]);
         cyc(6);
         chk({hy[i][0] ? b_pin : a_pin, rst_pin}, {2{hy[i][2][0]}}, "hyst");
      end
      $display("comparator test done");
      setv(0, 4990);
      cyc(6);
      gnd = 1'b1;
      sup = 1'b0;
      setv(0, 5020);
      meas(INT_CYC, "timer mode threshold");
      setv(0, 4990);
      cyc(6);
      setv(0, 5020);
      cyc(20);
      setv(0, 4990);
      cyc(6);
      chk({run, rst_pin}, 2'b00, "abort");
      setv(0, 5020);
      meas(INT_CYC, "restart from zero");
      $display("abort test done");
      reset_n = 1'b0;
      cyc(2);
      chk({rst_oe_n, a_oe_n, b_oe_n, run, mode}, 7'h01, "second reset");
      // Release into comparator mode with channel a invalid: no reset pulse allowed
      setv(0, 4990);
      gnd = 1'b0;
      sup = 1'b1;
      cyc(4);
      reset_n = 1'b1;
      for (k = 0; k < 6; k++) begin
         cyc(1);
         chk({rst_pin, run}, 2'b00, "release after reset");
      end
      setv(0, 5100);
      cyc(6);
      chk({rst_pin, mode}, 4'hC, "comparator after reset");
      $display("reset test done");
      end_sim();
   end
endmodule // smrt_reset_timer_tb
